/* rtl/pism_lem_counter.sv */
// Link error monitor down counter with zero detect
`timescale 1ns/1ps
module pism_lem_counter #(
  parameter int W = pism_pkg::LEM_W
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  input  wire logic         err_event,
  output logic              at_zero
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_value;
    end else if (err_event && (count_reg != '0)) begin
      // Stops at zero so the flag is not re-raised by wrap-around
      count_next = count_reg - W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= pism_pkg::LEM_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  assign at_zero = (count_reg == '0);

endmodule

/* rtl/pism_pkg.sv */
// Constants and types for the PHY interrupt summary and mask block
// Overview of operation
// - Condition A summary set on masked bank bit
// - Condition A summary clears only when none pending
// - Condition B summary set on masked bank bit
// - Condition B summary clears only when none pending
// - User sense interrupt set on any sense bit
// - User sense clears only when all senses zero
// - Interrupt pin low on any masked condition
// - Interrupt mask register resets to all zero
// - Link threshold flag sticky, set at counter zero
package pism_pkg;

  localparam int             ADDR_W        = 6;
  localparam int             DATA_W        = 8;
  localparam int             LEM_W         = 8;

  localparam logic [5:0]     ADDR_ICR      = 6'h02;
  localparam logic [5:0]     ADDR_INTERRUPT_ENABLE_MASK     = 6'h03;

  localparam logic [7:0]     INTERRUPT_ENABLE_MASK_RESET    = 8'h00;
  // Threshold flag is 1 out of reset because the counter starts at zero
  localparam logic [4:0]     ICR_LOW_RESET = 5'h10;
  localparam logic [7:0]     LEM_RESET     = 8'h00;

  localparam int             BIT_REQ_PAR   = 0;
  localparam int             BIT_BUS_PAR   = 1;
  localparam int             BIT_WR_REJ    = 2;
  localparam int             BIT_CWI       = 3;
  localparam int             BIT_LINK_ERROR_THRESHOLD_FLAG      = 4;
  localparam int             BIT_RCA       = 5;
  localparam int             BIT_RCB       = 6;
  localparam int             BIT_UDI       = 7;
  localparam int             STICKY_N      = 5;

  typedef struct packed {
    logic [5:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } pism_req_s;

  typedef struct packed {
    logic [7:0] bank_a;
    logic [7:0] mask_a;
    logic [7:0] bank_b;
    logic [7:0] mask_b;
    logic [2:0] sense;
  } pism_cond_s;

endpackage

/* rtl/pism_top.sv */
// Interrupt condition summary, mask register and interrupt pin
`timescale 1ns/1ps
module pism_top (
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire pism_pkg::pism_req_s bus_req,
  output logic [7:0]               bus_rdata,
  input  wire pism_pkg::pism_cond_s cond_in,
  input  wire logic                req_parity_err,
  input  wire logic                bus_parity_err,
  input  wire logic                write_reject_evt,
  input  wire logic                cond_write_inhibit_evt,
  input  wire logic                lem_error,
  input  wire logic                lem_load,
  input  wire logic [7:0]          lem_load_value,
  output logic                     int_n
);

  logic       rst_meta_reg;
  logic       rst_n;
  logic [7:0] interrupt_enable_mask_reg;
  logic [7:0] interrupt_enable_mask_next;
  logic [4:0] sticky_reg;
  logic [4:0] sticky_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       int_n_reg;
  logic       int_n_next;
  logic       lem_zero;
  logic       lem_zero_d_reg;
  logic       rx_cond_a_summary;
  logic       rx_cond_b_summary;
  logic       user_sense_interrupt;
  logic [7:0] interrupt_condition_summary;
  logic [4:0] events;

  function automatic logic masked_any(input logic [7:0] v, input logic [7:0] m);
    return |(v & m);
  endfunction

  // Reset release passes two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  pism_lem_counter #(
    .W (pism_pkg::LEM_W)
  ) u_lem (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .load       (lem_load),
    .load_value (lem_load_value),
    .err_event  (lem_error),
    .at_zero    (lem_zero)
  );

  // Summaries follow the sources directly, so software cannot clear them
  assign rx_cond_a_summary    = masked_any(cond_in.bank_a, cond_in.mask_a);
  assign rx_cond_b_summary    = masked_any(cond_in.bank_b, cond_in.mask_b);
  assign user_sense_interrupt = |cond_in.sense;

  assign interrupt_condition_summary = {user_sense_interrupt, rx_cond_b_summary,
                                        rx_cond_a_summary, sticky_reg};

  always_comb begin
    events                         = '0;
    events[pism_pkg::BIT_REQ_PAR]  = req_parity_err;
    events[pism_pkg::BIT_BUS_PAR]  = bus_parity_err;
    events[pism_pkg::BIT_WR_REJ]   = write_reject_evt;
    events[pism_pkg::BIT_CWI]      = cond_write_inhibit_evt;
    // Counter reaching zero sets once; holding at zero does not set again after a clear
    events[pism_pkg::BIT_LINK_ERROR_THRESHOLD_FLAG]     = lem_zero && !lem_zero_d_reg;
  end

  always_comb begin
    interrupt_enable_mask_next = interrupt_enable_mask_reg;
    sticky_next                = sticky_reg;
    if (bus_req.wr && (bus_req.addr == pism_pkg::ADDR_INTERRUPT_ENABLE_MASK)) begin
      interrupt_enable_mask_next = bus_req.wdata;
    end
    // Writing 0 to a low condition bit clears it; upper bits are read-only
    if (bus_req.wr && (bus_req.addr == pism_pkg::ADDR_ICR)) begin
      sticky_next = sticky_reg & bus_req.wdata[pism_pkg::STICKY_N-1:0];
    end
    // Set beats a same-cycle clear so no event is lost
    sticky_next = sticky_next | events;
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (bus_req.rd) begin
      case (bus_req.addr)
        pism_pkg::ADDR_ICR:  rdata_next = interrupt_condition_summary;
        pism_pkg::ADDR_INTERRUPT_ENABLE_MASK: rdata_next = interrupt_enable_mask_reg;
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  // Each mask bit gates only its own condition position
  assign int_n_next = !masked_any(interrupt_condition_summary,
                                  interrupt_enable_mask_reg);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable_mask_reg <= pism_pkg::INTERRUPT_ENABLE_MASK_RESET;
      sticky_reg                <= pism_pkg::ICR_LOW_RESET;
      lem_zero_d_reg            <= 1'b1;
      rdata_reg                 <= 8'h00;
      int_n_reg                 <= 1'b1;
    end else begin
      interrupt_enable_mask_reg <= interrupt_enable_mask_next;
      sticky_reg                <= sticky_next;
      lem_zero_d_reg            <= lem_zero;
      rdata_reg                 <= rdata_next;
      int_n_reg                 <= int_n_next;
    end
  end

  assign bus_rdata = rdata_reg;
  assign int_n     = int_n_reg;

endmodule

/* tb/pism_props.sv */
// Port checker for the interrupt summary and mask block
`timescale 1ns/1ps
module pism_props (
  input wire logic                 sys_clk,
  input wire logic                 resetn,
  input wire pism_pkg::pism_req_s  bus_req,
  input wire logic [7:0]           bus_rdata,
  input wire pism_pkg::pism_cond_s cond_in,
  input wire logic                 int_n
);
  logic [7:0] m_reg;
  logic [2:0] lv;
  assign lv = {|cond_in.sense, |(cond_in.bank_b & cond_in.mask_b),
               |(cond_in.bank_a & cond_in.mask_a)};
  // Shadow of the mask, since only the ports are visible here
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn) m_reg <= 8'h00;
    else if (bus_req.wr && bus_req.addr == 6'h03) m_reg <= bus_req.wdata;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence rd_at(logic [5:0] a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  chk_rx_a_pin: assert property (m_reg[5] && lv[0] |=> !int_n) else $error("a");
  chk_rx_b_pin: assert property (m_reg[6] && lv[1] |=> !int_n) else $error("b");
  chk_sense_pin: assert property (m_reg[7] && lv[2] |=> !int_n) else $error("s");
  chk_pin_quiet: assert property (m_reg[4:0] == 0 && (lv & m_reg[7:5]) == 0 |=> int_n)
    else $error("quiet");
  chk_mask_idle: assert property (m_reg == 8'h00 |=> int_n) else $error("idle");
  chk_summary_read: assert property (rd_at(6'h02) |=> bus_rdata[7:5] == $past(lv))
    else $error("sum");
  chk_mask_read: assert property (rd_at(6'h03) |=> bus_rdata == $past(m_reg))
    else $error("mask");
  chk_unmapped_read: assert property (rd_at(6'h3f) |=> bus_rdata == 8'h00)
    else $error("unmap");
endmodule
bind pism_top pism_props pism_props_inst (.sys_clk(sys_clk), .resetn(resetn),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .cond_in(cond_in), .int_n(int_n));

/* tb/pism_top_test.sv */
// Self-checking bench for the interrupt summary and mask block
`timescale 1ns/1ps
module pism_top_test;
  logic                 sys_clk = 1'b0;
  logic                 resetn  = 1'b0;
  pism_pkg::pism_req_s  req     = '0;
  pism_pkg::pism_cond_s cnd     = '0;
  logic [3:0]           ev      = 4'h0;
  logic                 lem_err = 1'b0;
  logic                 lem_ld  = 1'b0;
  logic [7:0]           bus_rdata;
  logic                 int_n;
  int                   fail_count   = 0;
  int                   total_checks = 0;
  always #20 sys_clk = ~sys_clk;
  pism_top pism_top_inst (.sys_clk(sys_clk), .resetn(resetn), .bus_req(req),
    .bus_rdata(bus_rdata), .cond_in(cnd), .req_parity_err(ev[0]), .bus_parity_err(ev[1]),
    .write_reject_evt(ev[2]), .cond_write_inhibit_evt(ev[3]), .lem_error(lem_err),
    .lem_load(lem_ld), .lem_load_value(8'h01), .int_n(int_n));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk) req <= '{a, 1'b1, 1'b0, d};
    @(posedge sys_clk) req <= '0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge sys_clk) req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge sys_clk) req <= '0;
    @(negedge sys_clk) chk("rdata", e, bus_rdata);
  endtask
  // Pin is registered, so allow the cause one edge plus one spare
  task automatic pin(input logic e);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) chk("int_n", {7'h0, e}, {7'h0, int_n});
  endtask
  task automatic t_reset;
    rd(6'h03, 8'h00);
    rd(6'h3f, 8'h00);
    pin(1'b1);
  endtask
  task automatic t_thresh;
    wr(6'h03, 8'h10);
    pin(1'b0);
    wr(6'h02, 8'h00);
    pin(1'b1);
    @(posedge sys_clk) lem_ld <= 1'b1;
    @(posedge sys_clk) lem_ld <= 1'b0;
    lem_err <= 1'b1;
    @(posedge sys_clk) lem_err <= 1'b0;
    pin(1'b0);
    wr(6'h02, 8'h00);
  endtask
  task automatic t_events;
    wr(6'h03, 8'h0f);
    pin(1'b1);
    @(posedge sys_clk) ev <= 4'hf;
    @(posedge sys_clk) ev <= 4'h0;
    pin(1'b0);
    rd(6'h02, 8'h0f);
    rd(6'h03, 8'h0f);
    wr(6'h02, 8'h00);
    pin(1'b1);
    // An event that lands on the clearing write must survive it
    @(posedge sys_clk) begin
      req <= '{6'h02, 1'b1, 1'b0, 8'h00};
      ev  <= 4'h1;
    end
    @(posedge sys_clk) begin
      req <= '0;
      ev  <= 4'h0;
    end
    rd(6'h02, 8'h01);
    wr(6'h02, 8'h00);
    rd(6'h02, 8'h00);
  endtask
  // Later sources stay live while an earlier one is unmasked, to prove the gating
  task automatic t_rx;
    @(posedge sys_clk) cnd <= '{8'h81, 8'h01, 8'h02, 8'h02, 3'h4};
    for (int k = 0; k < 3; k++) begin
      wr(6'h03, 8'h20 << k);
      pin(1'b0);
      rd(6'h02, 8'he0 << k);
      @(posedge sys_clk)
      case (k)
        0: cnd.mask_a <= 8'h00;
        1: cnd.bank_b <= 8'h00;
        default: cnd.sense <= 3'h0;
      endcase
      pin(1'b1);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset;
    t_thresh;
    t_events;
    t_rx;
    conclude;
  end
endmodule
